//--- rtl/tal_pkg.sv
// Constants, types and helpers for the thermal alarm output logic.
// Assumes conversion results and limits are two's complement words of
// TEMP_W bits, left aligned as in the temperature and limit registers.
package tal_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int TEMP_W = 16;
	localparam int CNT_W = 3;

	// ----------------------------------------------------------------
	// Fault queue thresholds, selected by the two queue bits
	// ----------------------------------------------------------------
	localparam logic [CNT_W-1:0] FQ_SEL_00 = 3'h1;
	localparam logic [CNT_W-1:0] FQ_SEL_01 = 3'h2;
	localparam logic [CNT_W-1:0] FQ_SEL_10 = 3'h4;
	localparam logic [CNT_W-1:0] FQ_SEL_11 = 3'h6;
	localparam logic [CNT_W-1:0] CNT_MAX = 3'h7;
	localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;

	// ----------------------------------------------------------------
	// Reset values of the alarm state, which has no boot copy
	// ----------------------------------------------------------------
	localparam logic RST_ALARM = 1'b0;
	localparam logic RST_EXPECT_LO = 1'b0;

	// ----------------------------------------------------------------
	// Single conversion alarm pulse in interrupt style
	// ----------------------------------------------------------------
	localparam int PULSE_NS = 1000;
	localparam int CLK_PERIOD_NS = 4;
	localparam int PULSE_CYCLES_INT = (PULSE_NS / CLK_PERIOD_NS) < 1 ? 1 :
		(PULSE_NS / CLK_PERIOD_NS);
	localparam int PULSE_W = 9;
	localparam logic [PULSE_W-1:0] PULSE_CYCLES =
		PULSE_CYCLES_INT[PULSE_W-1:0];
	localparam logic [PULSE_W-1:0] PULSE_ZERO = 9'h000;
	localparam logic [PULSE_W-1:0] PULSE_ONE = 9'h001;

	// ----------------------------------------------------------------
	// Conversion sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		ST_LOAD,
		ST_START,
		ST_WAIT,
		ST_SHUT
	} tal_seq_type;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic tal_at_or_above(
		input logic [TEMP_W-1:0] value,
		input logic [TEMP_W-1:0] limit
	);
		tal_at_or_above = $signed(value) >= $signed(limit);
	endfunction

	function automatic logic [CNT_W-1:0] tal_threshold(
		input logic hi_bit,
		input logic lo_bit
	);
		case ({hi_bit, lo_bit})
			2'b00: tal_threshold = FQ_SEL_00;
			2'b01: tal_threshold = FQ_SEL_01;
			2'b10: tal_threshold = FQ_SEL_10;
			default: tal_threshold = FQ_SEL_11;
		endcase
	endfunction

endpackage

//--- rtl/tal_fault_if.sv
// Interface between the alarm top and its consecutive-fault counter.
// Assumes all signals are on the conversion clock.
`timescale 1ns/100ps
interface tal_fault_if;
	logic eval;
	logic hi_hit;
	logic lo_hit;
	logic clear;
	logic [tal_pkg::CNT_W-1:0] threshold;
	logic qual_hi;
	logic qual_lo;
	logic held;
	logic held_hi;
	logic [tal_pkg::CNT_W-1:0] count;

	modport counter
	(
		input eval,
		input hi_hit,
		input lo_hit,
		input clear,
		input threshold,
		output qual_hi,
		output qual_lo,
		output held,
		output held_hi,
		output count
	);

	modport owner
	(
		output eval,
		output hi_hit,
		output lo_hit,
		output clear,
		output threshold,
		input qual_hi,
		input qual_lo,
		input held,
		input held_hi,
		input count
	);
endinterface

//--- rtl/tal_fault_count.sv
// Consecutive-fault counter with fault queue qualification.
// Assumes eval pulses once per stored conversion result.
`timescale 1ns/100ps
module tal_fault_count
(
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_reset,
	// Owner side
	tal_fault_if.counter fc
);

	logic [tal_pkg::CNT_W-1:0] count_q;
	logic [tal_pkg::CNT_W-1:0] count_d;
	logic last_hi_q;
	logic qual_hi_q;
	logic qual_lo_q;
	logic fault;

	assign fault = fc.hi_hit | fc.lo_hit;

	always_comb
	begin
		count_d = count_q;
		if (fc.eval)
		begin
			if (!fault)
				count_d = '0;
			else if (count_q != tal_pkg::CNT_MAX)
				count_d = count_q + tal_pkg::CNT_ONE;
		end
	end

	// ----------------------------------------------------------------
	// Counter, kept through shutdown, cleared by reset, clear or a result without fault
	// ----------------------------------------------------------------
	always_ff @(posedge i_mclk)
	begin
		if (i_reset || fc.clear)
			count_q <= '0;
		else
			count_q <= count_d;
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_reset || fc.clear)
			last_hi_q <= 1'b0;
		else if (fc.eval && fault)
			last_hi_q <= fc.hi_hit;
	end

	// ----------------------------------------------------------------
	// Qualified fault pulses, one per evaluation
	// ----------------------------------------------------------------
	always_ff @(posedge i_mclk)
	begin
		if (i_reset || fc.clear)
		begin
			qual_hi_q <= 1'b0;
			qual_lo_q <= 1'b0;
		end
		else
		begin
			qual_hi_q <= fc.eval && fc.hi_hit &&
				count_d >= fc.threshold;
			qual_lo_q <= fc.eval && fc.lo_hit && !fc.hi_hit &&
				count_d >= fc.threshold;
		end
	end

	assign fc.qual_hi = qual_hi_q;
	assign fc.qual_lo = qual_lo_q;
	assign fc.held = count_q >= fc.threshold;
	assign fc.held_hi = last_hi_q;
	assign fc.count = count_q;

endmodule // tal_fault_count

//--- rtl/tal_alarm.sv
// Alarm output logic of a digital temperature sensor: conversion
// sequencing for run, shutdown and single conversion, limit compare,
// fault queue and the comparator and interrupt alarm styles.
// Assumes the serial interface decodes register accesses into pulses
// and that the converter and boot storage run on the same clock.
`timescale 1ns/100ps
module tal_alarm
(
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_gcall_reset,
	// Boot copy of the configuration
	input wire logic i_boot_alarm_style_bit,
	input wire logic i_boot_shutdown_bit,
	input wire logic i_boot_alarm_polarity_bit,
	input wire logic i_boot_fault_queue_hi_bit,
	input wire logic i_boot_fault_queue_lo_bit,
	// Configuration write
	input wire logic i_cfg_wr,
	input wire logic i_alarm_style_bit,
	input wire logic i_shutdown_ctl_bit,
	input wire logic i_alarm_polarity_bit,
	input wire logic i_fault_queue_hi_bit,
	input wire logic i_fault_queue_lo_bit,
	input wire logic i_single_conv_bit,
	// Limits
	input wire logic [tal_pkg::TEMP_W-1:0] i_upper_limit_value,
	input wire logic [tal_pkg::TEMP_W-1:0] i_lower_limit_value,
	// Clear events from the serial side
	input wire logic i_reg_read,
	input wire logic i_ara_answer,
	// Converter
	input wire logic i_conv_done,
	input wire logic [tal_pkg::TEMP_W-1:0] i_conv_result,
	output logic o_conv_start,
	// Status
	output logic o_alarm_style_bit,
	output logic o_shutdown_ctl_bit,
	output logic o_alarm_polarity_bit,
	output logic o_fault_queue_hi_bit,
	output logic o_fault_queue_lo_bit,
	output logic o_single_conv_busy,
	output logic [tal_pkg::TEMP_W-1:0] o_temperature,
	output logic [tal_pkg::CNT_W-1:0] o_fault_count,
	output logic o_alarm_active,
	// Alarm pin
	output logic o_alert
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	tal_pkg::tal_seq_type seq_q;
	logic any_reset;
	logic style_q;
	logic sd_q;
	logic pol_q;
	logic fq_hi_q;
	logic fq_lo_q;
	logic one_shot_q;
	logic conv_start_q;
	logic eval_q;
	logic [tal_pkg::TEMP_W-1:0] temp_q;
	logic alarm_q;
	logic alarm_d;
	logic expect_lo_q;
	logic expect_lo_d;
	logic [tal_pkg::PULSE_W-1:0] pulse_q;
	logic [tal_pkg::PULSE_W-1:0] pulse_d;
	logic alert_q;
	logic sd_enter;
	logic sd_exit;
	logic clear_evt;
	logic set_hi;
	logic set_lo;
	logic exit_set;
	logic from_single_q;

	tal_fault_if fc();

	assign any_reset = i_reset | i_gcall_reset;
	assign sd_enter = i_cfg_wr && i_shutdown_ctl_bit && !sd_q;
	assign sd_exit = i_cfg_wr && !i_shutdown_ctl_bit && sd_q;

	// ----------------------------------------------------------------
	// Working configuration
	// ----------------------------------------------------------------
	always_ff @(posedge i_mclk)
	begin
		if (any_reset)
		begin
			style_q <= i_boot_alarm_style_bit;
			sd_q <= i_boot_shutdown_bit;
			pol_q <= i_boot_alarm_polarity_bit;
			fq_hi_q <= i_boot_fault_queue_hi_bit;
			fq_lo_q <= i_boot_fault_queue_lo_bit;
		end
		else if (i_cfg_wr)
		begin
			style_q <= i_alarm_style_bit;
			sd_q <= i_shutdown_ctl_bit;
			pol_q <= i_alarm_polarity_bit;
			fq_hi_q <= i_fault_queue_hi_bit;
			fq_lo_q <= i_fault_queue_lo_bit;
		end
	end

	// ----------------------------------------------------------------
	// Conversion sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge i_mclk)
	begin
		if (any_reset)
		begin
			seq_q <= tal_pkg::ST_LOAD;
			one_shot_q <= 1'b0;
		end
		else
		begin
			unique case (seq_q)
				tal_pkg::ST_LOAD:
				begin
					seq_q <= tal_pkg::ST_START;
					one_shot_q <= sd_q;
				end
				tal_pkg::ST_START:
					seq_q <= tal_pkg::ST_WAIT;
				tal_pkg::ST_WAIT:
				begin
					if (i_conv_done)
					begin
						one_shot_q <= 1'b0;
						if (one_shot_q || sd_q)
							seq_q <= tal_pkg::ST_SHUT;
						else
							seq_q <= tal_pkg::ST_START;
					end
				end
				tal_pkg::ST_SHUT:
				begin
					if (!sd_q)
						seq_q <= tal_pkg::ST_START;
					else if (i_cfg_wr && i_single_conv_bit &&
						i_shutdown_ctl_bit)
					begin
						seq_q <= tal_pkg::ST_START;
						one_shot_q <= 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (any_reset)
			conv_start_q <= 1'b0;
		else
			conv_start_q <= seq_q == tal_pkg::ST_START;
	end

	// ----------------------------------------------------------------
	// Result store and evaluation strobe
	// ----------------------------------------------------------------
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
			temp_q <= '0;
		else if (seq_q == tal_pkg::ST_WAIT && i_conv_done)
			temp_q <= i_conv_result;
	end

	always_ff @(posedge i_mclk)
	begin
		if (any_reset)
		begin
			eval_q <= 1'b0;
			from_single_q <= 1'b0;
		end
		else
		begin
			eval_q <= seq_q == tal_pkg::ST_WAIT && i_conv_done;
			// Taken in the done cycle and held until the next stored result
			if (seq_q == tal_pkg::ST_WAIT && i_conv_done)
				from_single_q <= one_shot_q;
		end
	end

	assign fc.eval = eval_q;
	assign fc.hi_hit = tal_pkg::tal_at_or_above(temp_q,
		i_upper_limit_value);
	assign fc.lo_hit = !tal_pkg::tal_at_or_above(temp_q,
		i_lower_limit_value);
	assign fc.clear = i_gcall_reset;
	assign fc.threshold = tal_pkg::tal_threshold(fq_hi_q, fq_lo_q);

	tal_fault_count u_fault_count
	(
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.fc(fc)
	);

	// ----------------------------------------------------------------
	// Alarm state
	// ----------------------------------------------------------------
	assign clear_evt = i_reg_read || i_ara_answer || sd_enter;
	assign set_hi = fc.qual_hi && !expect_lo_q && !alarm_q;
	assign set_lo = fc.qual_lo && expect_lo_q && !alarm_q;
	assign exit_set = sd_exit && fc.held &&
		(fc.held_hi != expect_lo_q) && !alarm_q;

	always_comb
	begin
		alarm_d = alarm_q;
		expect_lo_d = expect_lo_q;
		pulse_d = pulse_q;
		if (!style_q)
		begin
			// Comparator: only qualified faults move the alarm
			if (fc.qual_hi)
			begin
				alarm_d = 1'b1;
				expect_lo_d = 1'b1;
			end
			else if (fc.qual_lo)
			begin
				alarm_d = 1'b0;
				expect_lo_d = 1'b0;
			end
			pulse_d = tal_pkg::PULSE_ZERO;
		end
		else
		begin
			if (pulse_q == tal_pkg::PULSE_ONE)
				alarm_d = 1'b0;
			if (pulse_q != tal_pkg::PULSE_ZERO)
				pulse_d = pulse_q - tal_pkg::PULSE_ONE;
			if (clear_evt)
			begin
				alarm_d = 1'b0;
				pulse_d = tal_pkg::PULSE_ZERO;
			end
			// Set wins over a clear in the same cycle
			if (set_hi || set_lo || exit_set)
			begin
				alarm_d = 1'b1;
				expect_lo_d = !expect_lo_q;
				if (from_single_q && !exit_set)
					pulse_d = tal_pkg::PULSE_CYCLES;
			end
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (any_reset)
		begin
			alarm_q <= tal_pkg::RST_ALARM;
			expect_lo_q <= tal_pkg::RST_EXPECT_LO;
			pulse_q <= tal_pkg::PULSE_ZERO;
		end
		else
		begin
			alarm_q <= alarm_d;
			expect_lo_q <= expect_lo_d;
			pulse_q <= pulse_d;
		end
	end

	// ----------------------------------------------------------------
	// Pin drive and status
	// ----------------------------------------------------------------
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
			alert_q <= 1'b1;
		else
			alert_q <= alarm_q ? pol_q : !pol_q;
	end

	assign o_conv_start = conv_start_q;
	assign o_alarm_style_bit = style_q;
	assign o_shutdown_ctl_bit = sd_q;
	assign o_alarm_polarity_bit = pol_q;
	assign o_fault_queue_hi_bit = fq_hi_q;
	assign o_fault_queue_lo_bit = fq_lo_q;
	assign o_single_conv_busy = one_shot_q;
	assign o_temperature = temp_q;
	assign o_fault_count = fc.count;
	assign o_alarm_active = alarm_q;
	assign o_alert = alert_q;

endmodule // tal_alarm

//--- tb/tal_conv_model.sv
// Converter stand-in: answers each start pulse after a set delay.
// Assumes one start pulse per conversion from the alarm block.
`timescale 1ns/100ps
module tal_conv_model
(
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_reset,
	// Bench control
	input wire logic [7:0] i_delay,
	input wire logic [15:0] i_temp,
	// Alarm block side
	input wire logic i_start,
	output logic o_done,
	output logic [15:0] o_result
);
	logic [7:0] wait_q;

	// Result line toggles outside the done cycle
	always_ff @(posedge i_mclk)
	begin
		o_done <= !i_reset && wait_q == 8'h01;
		o_result <= (wait_q == 8'h01) ? i_temp : ~o_result;
		if (i_reset)
			wait_q <= 8'h00;
		else if (wait_q != 8'h00)
			wait_q <= wait_q - 8'h01;
		else if (i_start)
			wait_q <= i_delay;
	end
endmodule // tal_conv_model

//--- tb/tal_alarm_asserts.sv
// Port checker for the thermal alarm output logic.
// Assumes the converter only answers start pulses.
`timescale 1ns/100ps
module tal_alarm_chk
(
	// Clock and resets
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_gcall_reset,
	// Inputs watched
	input wire logic i_cfg_wr,
	input wire logic i_alarm_style_bit,
	input wire logic i_shutdown_ctl_bit,
	input wire logic i_reg_read,
	input wire logic i_ara_answer,
	input wire logic i_conv_done,
	input wire logic [tal_pkg::TEMP_W-1:0] i_conv_result,
	input wire logic [tal_pkg::TEMP_W-1:0] i_upper_limit_value,
	input wire logic [tal_pkg::TEMP_W-1:0] i_lower_limit_value,
	// Outputs watched
	input wire logic o_conv_start,
	input wire logic o_alarm_style_bit,
	input wire logic o_shutdown_ctl_bit,
	input wire logic o_alarm_polarity_bit,
	input wire logic o_single_conv_busy,
	input wire logic [tal_pkg::TEMP_W-1:0] o_temperature,
	input wire logic [tal_pkg::CNT_W-1:0] o_fault_count,
	input wire logic o_alarm_active,
	input wire logic o_alert
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_reset);
	logic [1:0] rst_age_q;

	// Counts down from 3 after the last reset of either kind, stops at 0
	always_ff @(posedge i_mclk)
	begin
		if (i_reset || i_gcall_reset)
			rst_age_q <= 2'h3;
		else if (rst_age_q != 2'h0)
			rst_age_q <= rst_age_q - 2'h1;
	end

	property p_alert_pol;
		!$past(i_reset) |-> o_alert ==
			($past(o_alarm_active) ~^ $past(o_alarm_polarity_bit));
	endproperty
	a_alert_pol: assert property (p_alert_pol)
		else $error("alert level wrong");
	property p_gcall;
		i_gcall_reset |=> !o_alarm_active;
	endproperty
	a_gcall: assert property (p_gcall)
		else $error("alarm kept after general call");
	property p_int_clear;
		o_alarm_style_bit && (i_reg_read || i_ara_answer) && !i_cfg_wr &&
			!$past(i_conv_done, 2) |=> !o_alarm_active;
	endproperty
	a_int_clear: assert property (p_int_clear)
		else $error("alarm not cleared");
	property p_sd_clear;
		i_cfg_wr && i_shutdown_ctl_bit && !o_shutdown_ctl_bit &&
			o_alarm_style_bit && i_alarm_style_bit &&
			!$past(i_conv_done, 2) |=> !o_alarm_active;
	endproperty
	a_sd_clear: assert property (p_sd_clear)
		else $error("alarm kept at shutdown");
	property p_comp_steady;
		!o_alarm_style_bit && !$past(i_cfg_wr) && !i_gcall_reset &&
			!$past(i_conv_done, 2) |=> $stable(o_alarm_active);
	endproperty
	a_comp_steady: assert property (p_comp_steady)
		else $error("alarm moved without result");
	property p_temp;
		i_conv_done |=> o_temperature == $past(i_conv_result);
	endproperty
	a_temp: assert property (p_temp)
		else $error("result not stored");
	property p_count_zero;
		i_conv_done && $signed(i_conv_result) < $signed(i_upper_limit_value)
			&& $signed(i_conv_result) >= $signed(i_lower_limit_value)
			|-> ##2 o_fault_count == 3'h0;
	endproperty
	a_count_zero: assert property (p_count_zero)
		else $error("count not cleared");
	property p_count_hold;
		!$past(i_conv_done) && !i_gcall_reset |=> $stable(o_fault_count);
	endproperty
	a_count_hold: assert property (p_count_hold)
		else $error("count moved without result");
	property p_sd_idle;
		rst_age_q == 2'h0 && o_shutdown_ctl_bit &&
			$past(o_shutdown_ctl_bit, 3) && !o_single_conv_busy &&
			!$past(o_single_conv_busy) |-> !o_conv_start;
	endproperty
	a_sd_idle: assert property (p_sd_idle)
		else $error("conversion in shutdown");
	c_comp: cover property (!o_alarm_style_bit && $rose(o_alarm_active));
	c_int: cover property (o_alarm_style_bit && $rose(o_alarm_active));
	c_single: cover property ($fell(o_single_conv_busy));
endmodule // tal_alarm_chk

bind tal_alarm tal_alarm_chk i_tal_alarm_chk (.*);

//--- tb/tal_alarm_bench.sv
// Self-checking bench for the thermal alarm output logic.
// Assumes the converter model answers every start pulse.
`timescale 1ns/100ps
module tal_alarm_bench;
	localparam logic [15:0] HOT = 16'h5000;
	localparam logic [15:0] MID = 16'h4c00;
	localparam logic [15:0] COLD = 16'h4a00;
	logic i_mclk, i_reset, i_gcall_reset, i_cfg_wr, i_reg_read;
	logic i_ara_answer, i_conv_done, i_boot_alarm_style_bit;
	logic i_boot_shutdown_bit, i_boot_alarm_polarity_bit;
	logic i_boot_fault_queue_hi_bit, i_boot_fault_queue_lo_bit;
	logic i_alarm_style_bit, i_shutdown_ctl_bit, i_alarm_polarity_bit;
	logic i_fault_queue_hi_bit, i_fault_queue_lo_bit, i_single_conv_bit;
	logic [15:0] i_upper_limit_value, i_lower_limit_value, i_conv_result;
	logic [15:0] o_temperature, temp;
	logic o_conv_start, o_alarm_style_bit, o_shutdown_ctl_bit;
	logic o_alarm_polarity_bit, o_fault_queue_hi_bit, o_fault_queue_lo_bit;
	logic o_single_conv_busy, o_alarm_active, o_alert;
	logic [2:0] o_fault_count, cnt;
	logic [7:0] dly;
	int miscompares, n_compared, starts, n0;

	tal_alarm i_tal_alarm (.*);
	tal_conv_model i_tal_conv_model (.i_mclk(i_mclk),
		.i_reset(i_reset || i_gcall_reset), .i_delay(dly), .i_temp(temp),
		.i_start(o_conv_start), .o_done(i_conv_done),
		.o_result(i_conv_result));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	initial
	begin
		i_mclk = 1'b0;
		forever #2 i_mclk = ~i_mclk;
	end
	always @(posedge i_mclk)
		if (o_conv_start === 1'b1)
			starts++;
	task automatic tally_and_finish;
		$display("Compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_mclk);
	endtask
	// Bits: style, shutdown, polarity, queue hi, queue lo, single
	task automatic cfg(input logic [5:0] c);
		@(posedge i_mclk);
		i_cfg_wr <= 1'b1;
		{i_alarm_style_bit, i_shutdown_ctl_bit, i_alarm_polarity_bit,
			i_fault_queue_hi_bit, i_fault_queue_lo_bit,
			i_single_conv_bit} <= c;
		@(posedge i_mclk);
		i_cfg_wr <= 1'b0;
		tick(2);
	endtask
	task automatic conv(input int n);
		repeat (n) @(posedge i_conv_done);
		tick(6);
	endtask
	task automatic clr(input logic ara);
		@(posedge i_mclk);
		i_reg_read <= !ara;
		i_ara_answer <= ara;
		@(posedge i_mclk);
		i_reg_read <= 1'b0;
		i_ara_answer <= 1'b0;
		tick(2);
	endtask
	task automatic gcall;
		@(posedge i_mclk);
		i_gcall_reset <= 1'b1;
		@(posedge i_mclk);
		i_gcall_reset <= 1'b0;
		tick(2);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_comp;
		chk(o_alarm_style_bit, 1'b0);
		temp <= HOT;
		conv(1);
		chk(o_alarm_active, 1'b0);
		conv(1);
		chk(o_alarm_active, 1'b1);
		chk(o_alert, 1'b1);
		clr(1'b0);
		chk(o_alarm_active, 1'b1);
		temp <= MID;
		conv(1);
		chk(o_fault_count, 3'h0);
		temp <= COLD;
		conv(1);
		chk(o_alarm_active, 1'b1);
		conv(1);
		chk(o_alarm_active, 1'b0);
	endtask
	task automatic t_int;
		gcall;
		cfg(6'h2a);
		conv(2);
		chk(o_alarm_active, 1'b0);
		temp <= HOT;
		conv(2);
		chk(o_alarm_active, 1'b1);
		clr(1'b0);
		chk(o_alarm_active, 1'b0);
		conv(1);
		chk(o_alarm_active, 1'b0);
		temp <= COLD;
		conv(2);
		chk(o_alarm_active, 1'b1);
		clr(1'b1);
		chk(o_alarm_active, 1'b0);
		cfg(6'h22);
		chk(o_alert, 1'b1);
		chk(o_alarm_polarity_bit, 1'b0);
		chk(o_fault_queue_hi_bit, 1'b0);
		chk(o_fault_queue_lo_bit, 1'b1);
	endtask
	task automatic t_shut;
		cfg(6'h28);
		temp <= HOT;
		conv(1);
		chk(o_alarm_active, 1'b1);
		cfg(6'h38);
		chk(o_alarm_active, 1'b0);
		tick(50);
		cnt = o_fault_count;
		n0 = starts;
		tick(100);
		chk(o_fault_count, cnt);
		chk(16'(starts - n0), 16'h0);
		temp <= COLD;
		dly <= 8'h01;
		cfg(6'h39);
		tick(20);
		chk(o_alarm_active, 1'b1);
		chk(o_single_conv_busy, 1'b0);
		tick(300);
		chk(o_alarm_active, 1'b0);
		chk(16'(starts - n0), 16'h1);
		dly <= 8'h28;
	endtask
	task automatic t_switch;
		temp <= HOT;
		cfg(6'h28);
		conv(1);
		cfg(6'h08);
		temp <= MID;
		conv(1);
		chk(o_alarm_active, 1'b1);
		temp <= COLD;
		conv(1);
		chk(o_alarm_active, 1'b0);
		temp <= HOT;
		conv(1);
		cfg(6'h28);
		temp <= MID;
		conv(1);
		chk(o_alarm_active, 1'b1);
		clr(1'b0);
		chk(o_alarm_active, 1'b0);
	endtask
	task automatic t_boot;
		temp <= COLD;
		conv(1);
		temp <= MID;
		i_boot_shutdown_bit <= 1'b1;
		i_boot_alarm_style_bit <= 1'b1;
		n0 = starts;
		gcall;
		chk(o_alarm_active, 1'b0);
		chk(o_alarm_style_bit, 1'b1);
		tick(100);
		chk(o_shutdown_ctl_bit, 1'b1);
		chk(16'(starts - n0), 16'h1);
		chk(o_temperature, MID);
	endtask

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial
	begin
		i_reset = 1'b1;
		{i_gcall_reset, i_cfg_wr, i_reg_read, i_ara_answer,
			i_boot_alarm_style_bit, i_boot_shutdown_bit,
			i_boot_fault_queue_hi_bit, i_alarm_style_bit,
			i_shutdown_ctl_bit, i_alarm_polarity_bit, i_fault_queue_hi_bit,
			i_fault_queue_lo_bit, i_single_conv_bit} = '0;
		i_boot_alarm_polarity_bit = 1'b1;
		i_boot_fault_queue_lo_bit = 1'b1;
		i_upper_limit_value = HOT;
		i_lower_limit_value = 16'h4b00;
		temp = MID;
		dly = 8'h28;
		repeat (8) @(posedge i_mclk);
		i_reset <= 1'b0;
		tick(1);
		t_comp;
		t_int;
		t_shut;
		t_switch;
		t_boot;
		tally_and_finish;
	end
	initial
	begin
		repeat (20000) @(posedge i_mclk);
		miscompares++;
		tally_and_finish;
	end
endmodule // tal_alarm_bench
